// file: include/cantf_pkg.sv
// shared constants for the transmit select / acceptance control register block
// assumes a 32-bit apb slave with byte addresses and registers in the low byte
package cantf_pkg;

	// ========================================================================
	// bus and register map
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam logic [7:0] OFS_TX_SEL = 8'h00;
	localparam logic [7:0] OFS_ACC_CTRL = 8'h04;
	localparam logic [7:0] OFS_MISC = 8'h08;
	localparam logic [7:0] OFS_RX_ERR = 8'h0c;
	localparam logic [7:0] OFS_TX_FLAG = 8'h10;
	localparam logic [7:0] OFS_WIN_BASE = 8'h40;
	localparam logic [7:0] OFS_WIN_LAST = 8'h7c;

	// ========================================================================
	// transmit buffers and access window
	localparam int NUM_TXBUF = 3;
	localparam int WIN_BYTES = 16;
	localparam int WIN_IDX_W = 4;
	localparam int MEM_ADDR_W = 6;
	localparam int MEM_DEPTH = NUM_TXBUF * WIN_BYTES;

	// ========================================================================
	// field positions
	localparam int TX_SEL_LSB = 0;
	localparam int TX_SEL_MSB = 2;
	localparam int ACC_MODE_LSB = 4;
	localparam int ACC_MODE_MSB = 5;
	localparam int HIT_LSB = 0;
	localparam int HIT_MSB = 2;
	localparam int BUSOFF_HOLD_BIT = 0;

	// ========================================================================
	// reset values and encodings
	localparam logic [2:0] TX_SEL_RESET = 3'h0;
	localparam logic [1:0] ACC_MODE_RESET = 2'h0;
	localparam logic [2:0] HIT_RESET = 3'h0;
	localparam logic [1:0] MODE_TWO_32 = 2'h0;
	localparam logic [1:0] MODE_FOUR_16 = 2'h1;
	localparam logic [1:0] MODE_EIGHT_8 = 2'h2;
	localparam logic [1:0] MODE_CLOSED = 2'h3;

	// ========================================================================
	// bus answer sequence
	typedef enum logic [0:0] {
		APB_IDLE,
		APB_ANSWER
	} cantf_apb_e;

endpackage : cantf_pkg

// file: sim/can_txsel_filter_ctrl_tb.sv
// bench: apb scenarios for select, acceptance and bus-off registers
// assumes cantf_regs as uut and cantf_ctl_model on the controller side
`timescale 1ns/1ps

module can_txsel_filter_ctrl_tb;
	import cantf_pkg::*;
	logic CLK = 1'b0;
	logic RST_N = 1'b0;
	logic PSEL = 1'b0;
	logic PENABLE = 1'b0;
	logic PWRITE = 1'b0;
	logic [ADDR_W-1:0] PADDR = '0;
	logic [DATA_W-1:0] PWDATA = '0;
	logic [DATA_W-1:0] PRDATA;
	logic PREADY, PSLVERR, BUSOFF_ENTER, RX_FG_SHIFT;
	logic INIT_REQUEST = 1'b0;
	logic INIT_ACK = 1'b0;
	logic SLEEP_REQUEST = 1'b0;
	logic SLEEP_ACK = 1'b0;
	logic BUSOFF_RECOVERY_MODE = 1'b0;
	logic [NUM_TXBUF-1:0] TX_EMPTY_FLAG, TX_WINDOW_SEL;
	logic [2:0] RX_FILTER_NUM;
	logic [7:0] RX_ERR_COUNT;
	logic [1:0] ACCEPTANCE_MODE;
	logic RX_ACCEPT_ENABLE, BUSOFF_HOLD, BUSOFF_RECOVER_REQ;
	int failures = 0;
	int cmp_count = 0;

	always #4 CLK = ~CLK;
	cantf_regs uut (.*);
	cantf_ctl_model mdl (.clk(CLK), .tx_empty(TX_EMPTY_FLAG),
		.busoff_enter(BUSOFF_ENTER), .rx_shift(RX_FG_SHIFT),
		.rx_num(RX_FILTER_NUM), .rx_err(RX_ERR_COUNT));

	// ========================================================================
	// shared tasks
	task automatic complete_run();
		$display("compares %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : complete_run
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			failures++;
			$display("ERROR at %0t seen %h expected %h", $time, got, exp);
		end
	endtask : chk
	// one apb transfer; read data is 0 on writes and refusals
	task automatic xf(input logic w, input logic [7:0] a,
		input logic [31:0] d, input logic [31:0] exp, input logic e);
		int n;
		n = 0;
		@(posedge CLK);
		PSEL <= 1'b1;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= d;
		@(posedge CLK);
		PENABLE <= 1'b1;
		// ready, error and data are taken at the edge that sees ready high
		@(posedge CLK);
		while (PREADY !== 1'b1)
		begin
			n++;
			if (n > 16)
			begin
				failures++;
				complete_run();
			end
			else
				@(posedge CLK);
		end
		chk(PRDATA, exp);
		chk({31'h0, PSLVERR}, {31'h0, e});
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
	endtask : xf

	// ========================================================================
	// scenarios
	task automatic s_select_window();
		xf(1'b0, OFS_TX_SEL, 32'h0, 32'h0, 1'b0);
		xf(1'b0, 8'h20, 32'h0, 32'h0, 1'b1);
		mdl.set_state(3'h6, 8'h00);
		xf(1'b0, OFS_TX_FLAG, 32'h0, 32'h6, 1'b0);
		xf(1'b1, OFS_TX_SEL, 32'h6, 32'h0, 1'b0);
		xf(1'b0, OFS_TX_SEL, 32'h0, 32'h2, 1'b0);
		repeat (2) @(negedge CLK);
		chk({29'h0, TX_WINDOW_SEL}, 32'h2);
		xf(1'b1, OFS_WIN_BASE, 32'ha5, 32'h0, 1'b0);
		xf(1'b0, OFS_WIN_BASE, 32'h0, 32'ha5, 1'b0);
		xf(1'b1, OFS_TX_SEL, 32'h0, 32'h0, 1'b0);
		xf(1'b0, OFS_WIN_BASE, 32'h0, 32'h0, 1'b1);
		xf(1'b1, OFS_TX_SEL, 32'hfb, 32'h0, 1'b0);
		xf(1'b0, OFS_TX_SEL, 32'h0, 32'h1, 1'b0);
		xf(1'b1, OFS_WIN_LAST, 32'h3, 32'h0, 1'b1);
		mdl.set_state(3'h7, 8'h00);
		xf(1'b1, OFS_WIN_BASE, 32'h5a, 32'h0, 1'b0);
		xf(1'b0, OFS_WIN_BASE, 32'h0, 32'h5a, 1'b0);
		xf(1'b1, OFS_TX_SEL, 32'h2, 32'h0, 1'b0);
		xf(1'b0, OFS_WIN_BASE, 32'h0, 32'ha5, 1'b0);
	endtask : s_select_window
	task automatic s_init_filter();
		@(posedge CLK);
		INIT_REQUEST <= 1'b1;
		INIT_ACK <= 1'b1;
		mdl.set_state(3'h7, 8'h3c);
		xf(1'b1, OFS_TX_SEL, 32'h4, 32'h0, 1'b0);
		xf(1'b0, OFS_TX_SEL, 32'h0, 32'h0, 1'b0);
		chk({29'h0, TX_WINDOW_SEL}, 32'h0);
		for (int m = 0; m < 4; m++)
		begin
			xf(1'b1, OFS_ACC_CTRL, 32'(m << 4), 32'h0, 1'b0);
			xf(1'b0, OFS_ACC_CTRL, 32'h0, 32'(m << 4), 1'b0);
		end
		chk({31'h0, RX_ACCEPT_ENABLE}, 32'h0);
		mdl.rx_msg(3'h5);
		xf(1'b0, OFS_ACC_CTRL, 32'h0, 32'h30, 1'b0);
		xf(1'b1, OFS_ACC_CTRL, 32'h0, 32'h0, 1'b0);
		mdl.rx_msg(3'h7);
		chk({31'h0, RX_ACCEPT_ENABLE}, 32'h1);
		xf(1'b1, OFS_ACC_CTRL, 32'h10, 32'h0, 1'b0);
		xf(1'b0, OFS_ACC_CTRL, 32'h0, 32'h17, 1'b0);
		chk({30'h0, ACCEPTANCE_MODE}, 32'h1);
		xf(1'b1, OFS_RX_ERR, 32'hff, 32'h0, 1'b0);
		xf(1'b0, OFS_RX_ERR, 32'h0, 32'h3c, 1'b0);
		@(posedge CLK);
		INIT_REQUEST <= 1'b0;
		INIT_ACK <= 1'b0;
		xf(1'b1, OFS_ACC_CTRL, 32'h27, 32'h0, 1'b0);
		xf(1'b0, OFS_ACC_CTRL, 32'h0, 32'h17, 1'b0);
		chk({30'h0, ACCEPTANCE_MODE}, 32'h1);
	endtask : s_init_filter
	task automatic s_busoff_sleep();
		@(posedge CLK);
		BUSOFF_RECOVERY_MODE <= 1'b1;
		SLEEP_REQUEST <= 1'b1;
		SLEEP_ACK <= 1'b1;
		mdl.set_state(3'h7, 8'h81);
		mdl.busoff();
		xf(1'b0, OFS_RX_ERR, 32'h0, 32'h81, 1'b0);
		xf(1'b1, OFS_MISC, 32'hfe, 32'h0, 1'b0);
		@(posedge CLK);
		chk({31'h0, BUSOFF_RECOVER_REQ}, 32'h0);
		xf(1'b0, OFS_MISC, 32'h0, 32'h1, 1'b0);
		chk({31'h0, BUSOFF_HOLD}, 32'h1);
		xf(1'b1, OFS_MISC, 32'h1, 32'h0, 1'b0);
		// the recovery pulse stands for the one cycle after the clear lands
		@(posedge CLK);
		chk({31'h0, BUSOFF_RECOVER_REQ}, 32'h1);
		xf(1'b0, OFS_MISC, 32'h0, 32'h0, 1'b0);
		@(posedge CLK);
		BUSOFF_RECOVERY_MODE <= 1'b0;
		mdl.busoff();
		xf(1'b0, OFS_MISC, 32'h0, 32'h0, 1'b0);
	endtask : s_busoff_sleep

	initial
	begin
		repeat (2) @(posedge CLK);
		RST_N <= 1'b1;
		s_select_window();
		s_init_filter();
		s_busoff_sleep();
		complete_run();
	end
endmodule : can_txsel_filter_ctrl_tb

// file: sim/cantf_ctl_model.sv
// controller-side model: empty flags, receive events, bus-off, error count
// assumes its tasks are called by the bench right after a clock edge
`timescale 1ns/1ps

module cantf_ctl_model
	import cantf_pkg::*;
(
	input wire logic clk,
	output logic [cantf_pkg::NUM_TXBUF-1:0] tx_empty,
	output logic busoff_enter,
	output logic rx_shift,
	output logic [2:0] rx_num,
	output logic [7:0] rx_err
);
	initial
	begin
		tx_empty = 3'h7;
		busoff_enter = 1'b0;
		rx_shift = 1'b0;
		rx_num = 3'h0;
		rx_err = 8'h00;
	end
	// filter number is scrambled outside its valid cycle
	task automatic rx_msg(input logic [2:0] n);
		@(posedge clk);
		rx_shift <= 1'b1;
		rx_num <= n;
		@(posedge clk);
		rx_shift <= 1'b0;
		rx_num <= ~n;
	endtask : rx_msg
	// level inputs change only here, so each has one writer
	task automatic set_state(input logic [2:0] e, input logic [7:0] r);
		@(posedge clk);
		tx_empty <= e;
		rx_err <= r;
	endtask : set_state
	task automatic busoff();
		@(posedge clk);
		busoff_enter <= 1'b1;
		@(posedge clk);
		busoff_enter <= 1'b0;
	endtask : busoff
endmodule : cantf_ctl_model

// file: sim/cantf_regs_checker.sv
// checker: apb answer, select, mode and bus-off relations of cantf_regs
// assumes a bind to cantf_regs, whose port names it repeats
`timescale 1ns/1ps

module cantf_regs_checker
	import cantf_pkg::*;
(
	input wire logic CLK,
	input wire logic RST_N,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic [cantf_pkg::DATA_W-1:0] PRDATA,
	input wire logic PREADY,
	input wire logic PSLVERR,
	input wire logic INIT_REQUEST,
	input wire logic INIT_ACK,
	input wire logic BUSOFF_RECOVERY_MODE,
	input wire logic BUSOFF_ENTER,
	input wire logic [cantf_pkg::NUM_TXBUF-1:0] TX_WINDOW_SEL,
	input wire logic [1:0] ACCEPTANCE_MODE,
	input wire logic RX_ACCEPT_ENABLE,
	input wire logic BUSOFF_HOLD,
	input wire logic BUSOFF_RECOVER_REQ
);
	import cantf_pkg::*;
	default clocking @(posedge CLK); endclocking
	default disable iff (!RST_N);
	// ========================================================================
	// assertions
	a_sel_init_clr: assert property ((INIT_REQUEST && INIT_ACK)[*2] |=>
		TX_WINDOW_SEL == 3'h0) else $error("select kept in init");
	a_sel_one_hot: assert property ($onehot0(TX_WINDOW_SEL))
		else $error("window select not one-hot");
	a_ready_pulse: assert property ($rose(PSEL && PENABLE) |=>
		PREADY ##1 !PREADY) else $error("answer timing wrong");
	a_err_no_data: assert property (PREADY && PSLVERR |->
		PRDATA == 32'h0) else $error("data on refused access");
	a_mode_init_only: assert property ($changed(ACCEPTANCE_MODE) |->
		$past(INIT_REQUEST && INIT_ACK)) else $error("mode changed in run");
	a_closed_accept: assert property (ACCEPTANCE_MODE == MODE_CLOSED |=>
		!RX_ACCEPT_ENABLE) else $error("closed mode accepts");
	a_hold_set: assert property (BUSOFF_ENTER && BUSOFF_RECOVERY_MODE |=>
		BUSOFF_HOLD) else $error("hold not set");
	a_hold_cause: assert property ($rose(BUSOFF_HOLD) |->
		$past(BUSOFF_ENTER && BUSOFF_RECOVERY_MODE)) else $error("hold uncaused");
	a_recover_req: assert property ($fell(BUSOFF_HOLD) |->
		##[0:1] BUSOFF_RECOVER_REQ) else $error("no recovery request");
	c_refused: cover property (PREADY && PSLVERR);
	c_closed: cover property (!RX_ACCEPT_ENABLE);
	c_recover: cover property (BUSOFF_RECOVER_REQ);
endmodule : cantf_regs_checker

bind cantf_regs cantf_regs_checker chk_i (.*);

// file: verilog/cantf_regs.sv
// register logic for transmit buffer select, acceptance control, bus-off hold
// and receive error visibility, reached over apb
// assumes init/sleep handshakes, tx empty flags and receive events are
// synchronous to CLK and driven by the rest of the controller
//
// Overview of operation
// R01: select register forced to reset while init request and ack both high
// R02: select register written only when init request and ack both low
// R03: select read returns only its lowest set bit, others zero
// R04: window maps the buffer of the lowest set select bit
// R05: window access blocked while selected buffer is scheduled, empty flag low
// R06: no window access when no select bit is set
// R07: software reads the flag register and writes it to select
// R08: acceptance control written only in init mode; filter hit read-only
// R09: mode bits 5:4 pick 2x32, 4x16, 8x8 filters or closed
// R10: closed mode accepts nothing and never reloads the foreground buffer
// R11: filter hit bits 2:0 give the number of the matching filter
// R12: filter hit follows the foreground buffer, updated on each shift in
// R13: misc register flags clear on written one, zero ignored
// R14: bus-off hold set on bus-off entry if enabled; clearing asks recovery
// R15: receive error count valid only in sleep or init; writes ignored
// R16: receive error count readable as a read-only register
// R17: tx empty flag reads one when empty, zero when scheduled
// R18: unused upper register bits read zero and ignore writes
`timescale 1ns/1ps

module cantf_regs
	import cantf_pkg::*;
(
	input wire logic CLK,
	input wire logic RST_N,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [cantf_pkg::ADDR_W-1:0] PADDR,
	input wire logic [cantf_pkg::DATA_W-1:0] PWDATA,
	output logic [cantf_pkg::DATA_W-1:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	input wire logic INIT_REQUEST,
	input wire logic INIT_ACK,
	input wire logic SLEEP_REQUEST,
	input wire logic SLEEP_ACK,
	input wire logic [cantf_pkg::NUM_TXBUF-1:0] TX_EMPTY_FLAG,
	input wire logic BUSOFF_RECOVERY_MODE,
	input wire logic BUSOFF_ENTER,
	input wire logic RX_FG_SHIFT,
	input wire logic [2:0] RX_FILTER_NUM,
	input wire logic [7:0] RX_ERR_COUNT,
	output logic [cantf_pkg::NUM_TXBUF-1:0] TX_WINDOW_SEL,
	output logic [1:0] ACCEPTANCE_MODE,
	output logic RX_ACCEPT_ENABLE,
	output logic BUSOFF_HOLD,
	output logic BUSOFF_RECOVER_REQ
);

	// ========================================================================
	// helpers
	function automatic logic [2:0] lowest_bit(input logic [2:0] v);
		logic [2:0] r;
		r = 3'h0;
		if (v[0])
			r = 3'h1;
		else if (v[1])
			r = 3'h2;
		else if (v[2])
			r = 3'h4;
		return r;
	endfunction : lowest_bit

	function automatic logic [1:0] buf_index(input logic [2:0] onehot);
		logic [1:0] r;
		r = 2'h0;
		if (onehot[1])
			r = 2'h1;
		else if (onehot[2])
			r = 2'h2;
		return r;
	endfunction : buf_index

	// ========================================================================
	// state
	cantf_apb_e apb_st_q;
	logic pready_q;
	logic pslverr_q;
	logic [31:0] prdata_q;
	logic [2:0] tx_sel_q;
	logic [1:0] acc_mode_q;
	logic [2:0] hit_q;
	logic hold_q;
	logic recover_q;
	logic [2:0] win_sel_q;
	logic accept_en_q;
	logic [7:0] mem_rdata;

	logic init_mode;
	logic run_mode;
	logic [2:0] sel_low;
	logic win_hit;
	logic win_blocked;
	logic known_addr;
	logic bad_access;
	logic wr_fire;
	logic clr_hold;
	logic [cantf_pkg::MEM_ADDR_W-1:0] mem_addr;
	logic [31:0] rd_value;

	assign init_mode = INIT_REQUEST && INIT_ACK;
	assign run_mode = !INIT_REQUEST && !INIT_ACK;
	assign sel_low = lowest_bit(tx_sel_q);                         // R04

	// ========================================================================
	// address decode
	assign win_hit = (PADDR >= OFS_WIN_BASE) && (PADDR <= OFS_WIN_LAST)
		&& (PADDR[1:0] == 2'h0);
	// blocked when nothing is selected or the chosen buffer is queued
	assign win_blocked = (sel_low == 3'h0)                         // R06
		|| ((sel_low & TX_EMPTY_FLAG) == 3'h0);                    // R05
	always_comb
	begin
		unique case (PADDR)
			OFS_TX_SEL, OFS_ACC_CTRL, OFS_MISC, OFS_RX_ERR, OFS_TX_FLAG:
				known_addr = 1'b1;
			default:
				known_addr = win_hit;
		endcase
	end
	assign bad_access = !known_addr || (win_hit && win_blocked);
	assign wr_fire = PSEL && PENABLE && PWRITE && pready_q && !bad_access;
	assign mem_addr = {buf_index(sel_low), PADDR[WIN_IDX_W+1:2]};

	// ========================================================================
	// read mux, unused bits zero
	always_comb
	begin
		rd_value = 32'h0;                                          // R18
		if (win_hit)
			rd_value[7:0] = win_blocked ? 8'h00 : mem_rdata;
		else
		begin
			unique case (PADDR)
				OFS_TX_SEL:
					rd_value[TX_SEL_MSB:TX_SEL_LSB] = sel_low;     // R03
				OFS_ACC_CTRL:
				begin
					rd_value[ACC_MODE_MSB:ACC_MODE_LSB] = acc_mode_q;
					rd_value[HIT_MSB:HIT_LSB] = hit_q;             // R11
				end
				OFS_MISC:
					rd_value[BUSOFF_HOLD_BIT] = hold_q;
				// value is only trustworthy in sleep or init mode
				OFS_RX_ERR:
					rd_value[7:0] = RX_ERR_COUNT;                  // R15 R16
				// software copies this into select to pick a free buffer
				OFS_TX_FLAG:
					rd_value[TX_SEL_MSB:TX_SEL_LSB] = TX_EMPTY_FLAG; // R17 R07
				default:
					rd_value = 32'h0;
			endcase
		end
	end

	// ========================================================================
	// apb answer: one wait state so window read data can settle
	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			apb_st_q <= APB_IDLE;
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h0;
		end
		else
		begin
			unique case (apb_st_q)
				APB_IDLE:
				begin
					if (PSEL && PENABLE)
					begin
						apb_st_q <= APB_ANSWER;
						pready_q <= 1'b1;
						pslverr_q <= bad_access;
						prdata_q <= (PWRITE || bad_access) ? 32'h0 : rd_value;
					end
				end
				APB_ANSWER:
				begin
					apb_st_q <= APB_IDLE;
					pready_q <= 1'b0;
					pslverr_q <= 1'b0;
				end
			endcase
		end
	end

	// ========================================================================
	// transmit buffer select
	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			tx_sel_q <= TX_SEL_RESET;
		end
		else if (init_mode)
		begin
			tx_sel_q <= TX_SEL_RESET;                              // R01
		end
		else if (wr_fire && run_mode && PADDR == OFS_TX_SEL)
		begin
			tx_sel_q <= PWDATA[TX_SEL_MSB:TX_SEL_LSB];             // R02 R18
		end
	end

	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			win_sel_q <= TX_SEL_RESET;
		end
		else
		begin
			win_sel_q <= sel_low;                                  // R04
		end
	end

	// ========================================================================
	// acceptance mode and filter hit
	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			acc_mode_q <= ACC_MODE_RESET;
		end
		else if (wr_fire && init_mode && PADDR == OFS_ACC_CTRL)
		begin
			acc_mode_q <= PWDATA[ACC_MODE_MSB:ACC_MODE_LSB];       // R08 R09
		end
	end

	// hit bits are never written by software
	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			hit_q <= HIT_RESET;
		end
		else if (RX_FG_SHIFT && acc_mode_q != MODE_CLOSED)
		begin
			hit_q <= RX_FILTER_NUM;                                // R12 R10
		end
	end

	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			accept_en_q <= 1'b1;
		end
		else
		begin
			accept_en_q <= (acc_mode_q != MODE_CLOSED);            // R10
		end
	end

	// ========================================================================
	// bus-off hold, write one to clear; a new entry beats a clear
	assign clr_hold = wr_fire && PADDR == OFS_MISC
		&& PWDATA[BUSOFF_HOLD_BIT];                                // R13

	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			hold_q <= 1'b0;
		end
		else if (BUSOFF_ENTER && BUSOFF_RECOVERY_MODE)
		begin
			hold_q <= 1'b1;                                        // R14
		end
		else if (clr_hold)
		begin
			hold_q <= 1'b0;                                        // R13
		end
	end

	// recovery asked only when a held state is really released
	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			recover_q <= 1'b0;
		end
		else
		begin
			recover_q <= clr_hold && hold_q
				&& !(BUSOFF_ENTER && BUSOFF_RECOVERY_MODE);        // R14
		end
	end

	// ========================================================================
	// window storage
	cantf_txbuf_mem u_mem (
		.clk(CLK),
		.rst_n(RST_N),
		.wr_en(wr_fire && win_hit),                                // R05 R06
		.addr(mem_addr),
		.wdata(PWDATA[7:0]),
		.rdata(mem_rdata)
	);

	// ========================================================================
	// outputs
	assign PRDATA = prdata_q;
	assign PREADY = pready_q;
	assign PSLVERR = pslverr_q;
	assign TX_WINDOW_SEL = win_sel_q;
	assign ACCEPTANCE_MODE = acc_mode_q;
	assign RX_ACCEPT_ENABLE = accept_en_q;
	assign BUSOFF_HOLD = hold_q;
	assign BUSOFF_RECOVER_REQ = recover_q;

endmodule : cantf_regs

// file: verilog/cantf_txbuf_mem.sv
// storage behind the shared transmit access window, three buffers of bytes
// assumes the caller gates writes; read data come one clock after address
`timescale 1ns/1ps

module cantf_txbuf_mem
	import cantf_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic wr_en,
	input wire logic [cantf_pkg::MEM_ADDR_W-1:0] addr,
	input wire logic [7:0] wdata,
	output logic [7:0] rdata
);

	// ========================================================================
	// storage
	logic [7:0] mem_q [cantf_pkg::MEM_DEPTH];
	logic [7:0] rdata_q;

	// no reset on the array: contents are undefined until software loads them
	always_ff @(posedge clk)
	begin
		if (wr_en)
		begin
			mem_q[addr] <= wdata;
		end
	end

	// ========================================================================
	// registered read port
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rdata_q <= 8'h00;
		end
		else
		begin
			rdata_q <= mem_q[addr];
		end
	end

	assign rdata = rdata_q;

endmodule : cantf_txbuf_mem
